// File: hdl/idr_pkg.sv
// Package for the I/O decode and interrupt/DMA routing register bank.
// Assumes a single synchronous clock and an index/data configuration port.
package idr_pkg;
    localparam logic [7:0] IDX_RSVD_A = 8'h21;
    localparam logic [7:0] IDX_RSVD_B = 8'h22;
    localparam logic [7:0] IDX_PP_BASE = 8'h23;
    localparam logic [7:0] IDX_UART1_BASE = 8'h24;
    localparam logic [7:0] IDX_UART2_BASE = 8'h25;
    localparam logic [7:0] IDX_PP_DMA = 8'h26;
    localparam logic [7:0] IDX_PP_IRQ = 8'h27;
    localparam logic [7:0] IDX_UART_IRQ = 8'h28;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [1:0] BASE_HI_OFF = 2'h0;
    localparam logic [3:0] SEL_NONE = 4'h0;
    localparam logic [3:0] IRQ_SEL_RSVD = 4'h7;
    localparam logic [3:0] IRQ_SEL_H = 4'h8;
    localparam logic [3:0] IRQ_SEL_SHARE = 4'hf;
    localparam int IRQ_LINES = 8;
    localparam int DMA_LINES = 3;
    // Index of line H in the output vector (G is not used)
    localparam logic [3:0] IRQ_BIT_H = 4'h7;

    typedef enum logic [1:0] {
        IDR_PP_COMPAT,
        IDR_PP_BIDIR,
        IDR_PP_EPP,
        IDR_PP_ECP
    } idr_pp_mode_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic index_sel;
        logic [7:0] wdata;
    } idr_cfg_req_t;

    typedef struct packed {
        logic chip_select_n;
        logic host_addr_bit10;
        logic [9:0] addr;
    } idr_host_addr_t;

    typedef struct packed {
        logic [IRQ_LINES-1:0] out;
        logic [IRQ_LINES-1:0] oe;
    } idr_irq_pins_t;

    typedef struct packed {
        logic [DMA_LINES-1:0] out;
        logic [DMA_LINES-1:0] oe;
    } idr_dma_pins_t;
endpackage

// File: hdl/idr_routing.sv
// Configuration registers for host decode windows and IRQ/DMA routing.
// Assumes config-state entry, the UARTs and parallel port live outside.
// Every output is registered, so selects lag the host address by one clock.
// Summary of operation
// RL1: Reserved 21h/22h ignore writes, read zero
// RL2: Access only in config state; reset 00h
// RL3: Non-EPP: base bits 9..2, 4-byte windows
// RL4: EPP: 8-byte windows, A[2:0] select
// RL5: Parallel port off when base bits 9,8 zero
// RL6: Parallel decode needs CS low, A10 low except in ECP
// RL7: UART1 base bits 9..3 from register 7..1
// RL8: Software writes UART1 base bit0 zero
// RL9: UART1 off when base bits 9,8 zero
// RL10: UART1 decode: CS low, A10 low, eight registers
// RL11: UART2 base bits 9..3; bit0 written zero
// RL12: UART2 off when base bits 9,8 zero
// RL13: UART2 decode: CS low, A10 low, eight registers
// RL14: Parallel DMA routed by select bits 3..0
// RL15: Unselected DMA outputs float
// RL16: Parallel IRQ routed by select bits 3..0
// RL17: Unselected IRQ lines float
// RL18: UART1 IRQ bits 7..4, UART2 bits 3..0
// RL19: UART2 field 1111b enables interrupt sharing
// RL20: Unshared line floats while gate bit low
// RL21: Shared: UART2 floats, UART1 carries OR
// RL22: Software never assigns two functions one line
// RL23: ECP with A10 high selects upper set
`default_nettype none

module idr_routing (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic config_state,
    input wire idr_pkg::idr_cfg_req_t cfg_req,
    output logic [7:0] cfg_rdata,
    input wire idr_pkg::idr_pp_mode_t pp_mode,
    input wire idr_pkg::idr_host_addr_t host_addr,
    output logic pp_select,
    output logic pp_upper_select,
    output logic [2:0] pp_reg_addr,
    output logic uart1_select,
    output logic uart2_select,
    output logic [2:0] uart_reg_addr,
    input wire logic pp_irq,
    input wire logic pp_dma_req,
    input wire logic uart1_irq,
    input wire logic uart2_irq,
    input wire logic uart1_irq_gate,
    input wire logic uart2_irq_gate,
    output idr_pkg::idr_irq_pins_t irq_pins,
    output idr_pkg::idr_dma_pins_t dma_pins
);
    logic [7:0] config_index_register;
    logic [7:0] parallel_port_base;
    logic [7:0] uart1_base;
    logic [7:0] uart2_base;
    logic [7:0] parallel_port_dma_select;
    logic [7:0] parallel_port_irq_select;
    logic [7:0] uart_irq_select;
    logic data_wr;
    logic data_rd;
    logic next_pp_select;
    logic next_pp_upper;
    logic next_u1_select;
    logic next_u2_select;
    logic pp_hit;
    logic pp_epp;
    logic pp_ecp;
    logic base_bit9;
    logic base_bit8;
    logic share;
    logic [3:0] u1_field;
    logic [3:0] u2_field;
    logic u1_drive;
    logic u1_level;
    logic u2_drive;
    logic u2_level;
    idr_pkg::idr_irq_pins_t next_irq;
    idr_pkg::idr_dma_pins_t next_dma;
    logic rdata_load;
    logic [7:0] next_cfg_rdata;
    logic [idr_pkg::IRQ_LINES-1:0] pp_m;
    logic [idr_pkg::IRQ_LINES-1:0] u1_m;
    logic [idr_pkg::IRQ_LINES-1:0] u2_m;
    wire logic [idr_pkg::IRQ_LINES-1:0] irq_oe_bits;
    wire logic [idr_pkg::IRQ_LINES-1:0] irq_out_bits;
    wire logic [idr_pkg::DMA_LINES-1:0] dma_oe_bits;
    wire logic [idr_pkg::DMA_LINES-1:0] dma_out_bits;

    // Index/data port is only live in configuration state
    // RL2: gate by config state
    assign data_wr = config_state && cfg_req.wr && !cfg_req.index_sel;
    assign data_rd = config_state && cfg_req.rd && !cfg_req.index_sel;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            config_index_register <= idr_pkg::REG_RESET;
        else if (config_state && cfg_req.wr && cfg_req.index_sel)
            config_index_register <= cfg_req.wdata;
    end

    // RL2: indexed writes, reset to 00h
    // RL1: reserved indices match no register
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            parallel_port_base <= idr_pkg::REG_RESET;
        else if (data_wr && config_index_register == idr_pkg::IDX_PP_BASE)
            parallel_port_base <= cfg_req.wdata;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            uart1_base <= idr_pkg::REG_RESET;
        else if (data_wr && config_index_register == idr_pkg::IDX_UART1_BASE)
            uart1_base <= cfg_req.wdata;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            uart2_base <= idr_pkg::REG_RESET;
        else if (data_wr && config_index_register == idr_pkg::IDX_UART2_BASE)
            uart2_base <= cfg_req.wdata;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            parallel_port_dma_select <= idr_pkg::REG_RESET;
        else if (data_wr && config_index_register == idr_pkg::IDX_PP_DMA)
            parallel_port_dma_select <= cfg_req.wdata;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            parallel_port_irq_select <= idr_pkg::REG_RESET;
        else if (data_wr && config_index_register == idr_pkg::IDX_PP_IRQ)
            parallel_port_irq_select <= cfg_req.wdata;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            uart_irq_select <= idr_pkg::REG_RESET;
        else if (data_wr && config_index_register == idr_pkg::IDX_UART_IRQ)
            uart_irq_select <= cfg_req.wdata;
    end

    always_comb
    begin
        rdata_load = config_state && cfg_req.rd;
        // RL1: reserved and unmapped read zero
        next_cfg_rdata = idr_pkg::READ_ZERO;
        if (cfg_req.index_sel)
            next_cfg_rdata = config_index_register;
        else if (data_rd && config_index_register == idr_pkg::IDX_PP_BASE)
            next_cfg_rdata = parallel_port_base;
        else if (data_rd && config_index_register == idr_pkg::IDX_UART1_BASE)
            next_cfg_rdata = uart1_base;
        else if (data_rd && config_index_register == idr_pkg::IDX_UART2_BASE)
            next_cfg_rdata = uart2_base;
        else if (data_rd && config_index_register == idr_pkg::IDX_PP_DMA)
            next_cfg_rdata = parallel_port_dma_select;
        else if (data_rd && config_index_register == idr_pkg::IDX_PP_IRQ)
            next_cfg_rdata = parallel_port_irq_select;
        else if (data_rd && config_index_register == idr_pkg::IDX_UART_IRQ)
            next_cfg_rdata = uart_irq_select;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            cfg_rdata <= idr_pkg::READ_ZERO;
        else if (rdata_load)
            cfg_rdata <= next_cfg_rdata;
    end

    // Host address decode
    assign pp_epp = (pp_mode == idr_pkg::IDR_PP_EPP);
    assign pp_ecp = (pp_mode == idr_pkg::IDR_PP_ECP);
    assign base_bit9 = parallel_port_base[7];
    assign base_bit8 = parallel_port_base[6];

    always_comb
    begin
        // RL3: 4-byte window, A[1:0] free
        pp_hit = (host_addr.addr[9:2] == parallel_port_base);
        // RL4: EPP uses 8-byte window
        if (pp_epp)
            pp_hit = (host_addr.addr[9:3] == parallel_port_base[7:1]);
        // RL5: disabled when top base bits zero
        if ({base_bit9, base_bit8} == idr_pkg::BASE_HI_OFF)
            pp_hit = 1'b0;
        // RL6: chip select required
        if (host_addr.chip_select_n)
            pp_hit = 1'b0;
        // RL6: A10 low except in ECP
        next_pp_select = pp_hit && (!host_addr.host_addr_bit10 || pp_ecp);
        // RL23: ECP upper register set
        next_pp_upper = pp_hit && pp_ecp && host_addr.host_addr_bit10;
    end

    always_comb
    begin
        next_u1_select = 1'b0;
        // RL10: CS low, A10 low
        if (!host_addr.chip_select_n && !host_addr.host_addr_bit10)
        begin
            // RL9: disabled by top bits zero
            // RL7: UART1 8-byte window
            if (uart1_base[7:6] != idr_pkg::BASE_HI_OFF)
                next_u1_select = (host_addr.addr[9:3] == uart1_base[7:1]);
        end
    end

    always_comb
    begin
        next_u2_select = 1'b0;
        // RL13: CS low, A10 low
        if (!host_addr.chip_select_n && !host_addr.host_addr_bit10)
        begin
            // RL12: disabled by top bits zero
            // RL11: UART2 8-byte window
            if (uart2_base[7:6] != idr_pkg::BASE_HI_OFF)
                next_u2_select = (host_addr.addr[9:3] == uart2_base[7:1]);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pp_select <= 1'b0;
            pp_upper_select <= 1'b0;
        end
        else
        begin
            pp_select <= next_pp_select;
            pp_upper_select <= next_pp_upper;
        end
    end

    // RL3 RL4: low register bits
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            pp_reg_addr <= 3'h0;
        else
            pp_reg_addr <= pp_epp ? host_addr.addr[2:0] : {1'b0, host_addr.addr[1:0]};
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            uart1_select <= 1'b0;
            uart2_select <= 1'b0;
        end
        else
        begin
            uart1_select <= next_u1_select;
            uart2_select <= next_u2_select;
        end
    end

    // RL10 RL13: eight UART registers
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            uart_reg_addr <= 3'h0;
        else
            uart_reg_addr <= host_addr.addr[2:0];
    end

    // Interrupt routing
    // RL18: field positions
    assign u1_field = uart_irq_select[7:4];
    assign u2_field = uart_irq_select[3:0];
    // RL19: 1111b selects sharing
    assign share = (u2_field == idr_pkg::IRQ_SEL_SHARE);

    always_comb
    begin
        if (share)
        begin
            // RL21: OR of gated sources on UART1 line
            u1_drive = uart1_irq_gate || uart2_irq_gate;
            u1_level = (uart1_irq_gate && uart1_irq) || (uart2_irq_gate && uart2_irq);
        end
        else
        begin
            // RL20: line gated by its own bit
            u1_drive = uart1_irq_gate;
            u1_level = uart1_irq;
        end
    end

    always_comb
    begin
        if (share)
        begin
            // RL21: UART2 line floats while shared
            u2_drive = 1'b0;
            u2_level = 1'b0;
        end
        else
        begin
            // RL20: line gated by its own bit
            u2_drive = uart2_irq_gate;
            u2_level = uart2_irq;
        end
    end

    // Maps a select code onto a line bit; 0 none, 7 and others unused
    function automatic logic [idr_pkg::IRQ_LINES-1:0] idr_line(input logic [3:0] code);
        logic [idr_pkg::IRQ_LINES-1:0] v;
        v = '0;
        // RL16: codes 1..6 lines A..F, 8 line H
        if (code == idr_pkg::IRQ_SEL_H)
            v[idr_pkg::IRQ_BIT_H[2:0]] = 1'b1;
        else if (code != idr_pkg::SEL_NONE && code < idr_pkg::IRQ_SEL_RSVD)
            v[3'(code - 4'h1)] = 1'b1;
        return v;
    endfunction

    always_comb
    begin
        pp_m = idr_line(parallel_port_irq_select[3:0]);
        u1_m = idr_line(u1_field);
        u2_m = share ? '0 : idr_line(u2_field);
    end

    // RL17: unselected lines left undriven
    // RL22: overlap relies on software; UART1 wins over others
    for (genvar i = 0; i < idr_pkg::IRQ_LINES; i++)
    begin : g_irq_line
        assign irq_oe_bits[i] = pp_m[i] || (u1_m[i] && u1_drive) || (u2_m[i] && u2_drive);
        assign irq_out_bits[i] = u1_m[i] ? u1_level : (u2_m[i] ? u2_level : pp_irq);
    end
    assign next_irq = {irq_out_bits, irq_oe_bits};

    // RL14: codes 1..3 select channels
    // RL15: others leave all channels floating
    for (genvar i = 0; i < idr_pkg::DMA_LINES; i++)
    begin : g_dma_chan
        assign dma_oe_bits[i] = (parallel_port_dma_select[3:0] == 4'(i + 1));
        assign dma_out_bits[i] = dma_oe_bits[i] && pp_dma_req;
    end
    assign next_dma = {dma_out_bits, dma_oe_bits};

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            irq_pins <= '0;
        else
            irq_pins <= next_irq;
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            dma_pins <= '0;
        else
            dma_pins <= next_dma;
    end
endmodule // idr_routing

`default_nettype wire

// File: testbench/idr_routing_sva.sv
// Checker for the decode and routing register bank.
// Assumes one clock and an asynchronous active-low reset.
`default_nettype none
module idr_routing_sva (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic config_state,
    input wire idr_pkg::idr_cfg_req_t cfg_req,
    input wire logic [7:0] cfg_rdata,
    input wire idr_pkg::idr_pp_mode_t pp_mode,
    input wire idr_pkg::idr_host_addr_t host_addr,
    input wire logic pp_select,
    input wire logic pp_upper_select,
    input wire logic [2:0] pp_reg_addr,
    input wire logic uart1_select,
    input wire logic uart2_select,
    input wire logic [2:0] uart_reg_addr,
    input wire idr_pkg::idr_irq_pins_t irq_pins,
    input wire idr_pkg::idr_dma_pins_t dma_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    cs_gate_a: assert property (
        host_addr.chip_select_n |=> !(pp_select || uart1_select || uart2_select))
        else $error("select without chip select");
    uart_a10_a: assert property (
        host_addr.host_addr_bit10 |=> !uart1_select && !uart2_select)
        else $error("uart select with A10 high");
    pp_a10_a: assert property (
        pp_select && $past(pp_mode) != idr_pkg::IDR_PP_ECP |-> !$past(host_addr.host_addr_bit10))
        else $error("parallel select with A10 high");
    pp_upper_a: assert property (
        pp_upper_select |-> pp_select && $past(host_addr.host_addr_bit10)
            && $past(pp_mode) == idr_pkg::IDR_PP_ECP)
        else $error("upper set outside extended mode");
    pp_low_a: assert property (
        pp_select |-> pp_reg_addr == ($past(pp_mode) == idr_pkg::IDR_PP_EPP ?
            $past(host_addr.addr[2:0]) : {1'b0, $past(host_addr.addr[1:0])}))
        else $error("parallel register address wrong");
    uart_low_a: assert property (
        uart1_select || uart2_select |-> uart_reg_addr == $past(host_addr.addr[2:0]))
        else $error("uart register address wrong");
    pp_off_a: assert property (
        pp_select |-> $past(host_addr.addr[9:8]) != idr_pkg::BASE_HI_OFF)
        else $error("parallel decode below 100h");
    uart_off_a: assert property (
        uart1_select || uart2_select |-> $past(host_addr.addr[9:8]) != idr_pkg::BASE_HI_OFF)
        else $error("uart decode below 100h");
    line_g_a: assert property (!irq_pins.oe[6])
        else $error("unused line driven");
    dma_one_a: assert property ($onehot0(dma_pins.oe))
        else $error("several dma lines driven");
    rdata_hold_a: assert property (
        !($past(cfg_req.rd) && $past(config_state)) |-> $stable(cfg_rdata))
        else $error("read data changed without read");
    cover property (pp_upper_select);
    cover property (uart2_select);
    cover property (irq_pins.oe[7]);
endmodule // idr_routing_sva
bind idr_routing idr_routing_sva u_idr_routing_sva (.ref_clk, .rstn, .config_state, .cfg_req,
    .cfg_rdata, .pp_mode, .host_addr, .pp_select, .pp_upper_select, .pp_reg_addr,
    .uart1_select, .uart2_select, .uart_reg_addr, .irq_pins, .dma_pins);
`default_nettype wire

// File: testbench/idr_host_model.sv
// Host-side view of the interrupt and DMA request lines.
// Assumes the pins come straight from the routing block.
`default_nettype none
module idr_host_model (
    input wire logic ref_clk,
    input wire idr_pkg::idr_irq_pins_t irq_pins,
    input wire idr_pkg::idr_dma_pins_t dma_pins,
    output logic [7:0] irq_seen,
    output logic [2:0] dma_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip = 1'b0;
    // Undriven lines wander every cycle
    always_ff @(posedge ref_clk)
        flip <= ~flip;
    assign irq_seen = (irq_pins.out & irq_pins.oe) | ({8{flip}} & ~irq_pins.oe);
    assign dma_seen = (dma_pins.out & dma_pins.oe) | ({3{flip}} & ~dma_pins.oe);
endmodule // idr_host_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the decode and routing register bank.
// Assumes the checker is bound and the host model resolves the pins.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rstn, config_state, pp_select, pp_upper_select, uart1_select, uart2_select;
    logic pp_irq, pp_dma_req, uart1_irq, uart2_irq, uart1_irq_gate, uart2_irq_gate;
    logic [7:0] cfg_rdata, irq_seen;
    logic [2:0] pp_reg_addr, uart_reg_addr, dma_seen;
    idr_pkg::idr_cfg_req_t cfg_req;
    idr_pkg::idr_pp_mode_t pp_mode;
    idr_pkg::idr_host_addr_t host_addr;
    idr_pkg::idr_irq_pins_t irq_pins;
    idr_pkg::idr_dma_pins_t dma_pins;
    int bad_count = 0;
    int total_checks = 0;
    always #2 ref_clk = ~ref_clk;
    idr_routing u_idr_routing (.ref_clk, .rstn, .config_state, .cfg_req, .cfg_rdata, .pp_mode,
        .host_addr, .pp_select, .pp_upper_select, .pp_reg_addr, .uart1_select, .uart2_select,
        .uart_reg_addr, .pp_irq, .pp_dma_req, .uart1_irq, .uart2_irq, .uart1_irq_gate,
        .uart2_irq_gate, .irq_pins, .dma_pins);
    idr_host_model u_idr_host_model (.ref_clk, .irq_pins, .dma_pins, .irq_seen, .dma_seen);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic r, input logic w, input logic s, input logic [7:0] dat);
        @(posedge ref_clk);
        #1 cfg_req = {r, w, s, dat};
        @(posedge ref_clk);
        #1 cfg_req = '0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
        acc(1'b0, 1'b1, 1'b1, idx);
        acc(1'b0, 1'b1, 1'b0, dat);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] dat);
        acc(1'b0, 1'b1, 1'b1, idx);
        acc(1'b1, 1'b0, 1'b0, 8'h00);
        dat = cfg_rdata;
    endtask
    task automatic dec(input logic [11:0] h, input logic [1:0] m, input logic [9:0] e);
        host_addr = h;
        pp_mode = idr_pkg::idr_pp_mode_t'(m);
        @(posedge ref_clk);
        #1 chk({pp_select, pp_upper_select, uart1_select, uart2_select, pp_reg_addr,
            uart_reg_addr}, e);
    endtask
    task automatic pin(input logic [15:0] e, input logic [5:0] d);
        @(posedge ref_clk);
        #1 chk({irq_pins.oe, irq_seen & irq_pins.oe}, e);
        chk({dma_pins.oe, dma_seen & dma_pins.oe}, d);
    endtask

    task automatic t_regs();
        logic [7:0] d;
        for (int i = 'h21; i <= 'h29; i++)
        begin
            rd(8'(i), d);
            chk(d, 8'h00);
            wr(8'(i), 8'(i << 2));
            rd(8'(i), d);
            chk(d, (i < 'h23 || i > 'h28) ? 8'h00 : 8'(i << 2));
        end
        config_state = 1'b0;
        wr(8'h27, 8'h11);
        config_state = 1'b1;
        rd(8'h27, d);
        chk(d, 8'h9c);
    endtask
    task automatic t_decode();
        wr(8'h23, 8'hc0);
        wr(8'h24, 8'hf0);
        wr(8'h25, 8'h02);
        dec(12'h303, 2'd0, 10'b1000_011_011);
        dec(12'h304, 2'd0, 10'b0000_000_100);
        dec(12'h307, 2'd2, 10'b1000_111_111);
        dec(12'h307, 2'd0, 10'b0000_011_111);
        dec(12'hb03, 2'd0, 10'b0000_011_011);
        dec(12'h703, 2'd1, 10'b0000_011_011);
        dec(12'h703, 2'd3, 10'b1100_011_011);
        dec(12'h3c7, 2'd0, 10'b0010_011_111);
        dec(12'h3c8, 2'd0, 10'b0000_000_000);
        dec(12'h7c7, 2'd0, 10'b0000_011_111);
        dec(12'h00a, 2'd0, 10'b0000_010_010);
        wr(8'h25, 8'h5e);
        dec(12'h17a, 2'd0, 10'b0001_010_010);
        dec(12'h97a, 2'd0, 10'b0000_010_010);
        wr(8'h23, 8'h3f);
        dec(12'h0fc, 2'd0, 10'b0000_000_100);
        wr(8'h23, 8'hff);
        dec(12'h3ff, 2'd0, 10'b1000_011_111);
        wr(8'h24, 8'h3e);
        dec(12'h0f8, 2'd0, 10'b0000_000_000);
    endtask
    task automatic t_route();
        logic [7:0] e;
        logic [2:0] d;
        logic sh, o1, o2, l1, l2;
        wr(8'h28, 8'h00);
        {pp_irq, pp_dma_req} = 2'b11;
        for (int c = 0; c <= 8; c++)
        begin
            wr(8'h26, c < 4 ? 8'(c) : 8'h00);
            wr(8'h27, 8'(c));
            e = (c == 0 || c == 7) ? 8'h00 : (c == 8 ? 8'h80 : 8'(1 << (c - 1)));
            d = (c == 0 || c > 3) ? 3'h0 : 3'(1 << (c - 1));
            pin({e, e}, {d, d});
        end
        pp_irq = 1'b0;
        pin(16'h8000, 6'h00);
        wr(8'h27, 8'h00);
        wr(8'h28, 8'h12);
        for (int g = 0; g < 32; g++)
        begin
            if (g == 16)
                wr(8'h28, 8'h1f);
            {uart1_irq_gate, uart2_irq_gate, uart1_irq, uart2_irq} = 4'(g);
            sh = (g >= 16);
            o1 = uart1_irq_gate | (sh & uart2_irq_gate);
            l1 = (uart1_irq_gate & uart1_irq) | (sh & uart2_irq_gate & uart2_irq);
            o2 = !sh & uart2_irq_gate;
            l2 = o2 & uart2_irq;
            pin({6'h00, o2, o1, 6'h00, l2, l1}, 6'h00);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        rstn = 1'b0;
        config_state = 1'b1;
        cfg_req = '0;
        pp_mode = idr_pkg::IDR_PP_COMPAT;
        host_addr = '0;
        {pp_irq, pp_dma_req, uart1_irq, uart2_irq, uart1_irq_gate, uart2_irq_gate} = '0;
        repeat (8) @(posedge ref_clk);
        #1 rstn = 1'b1;
        pin(16'h0000, 6'h00);
        t_regs();
        t_decode();
        t_route();
        tally_and_finish();
    end
    initial
    begin
        #20000;
        bad_count++;
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
